// File: hdl/adcsq_clk_if.sv
// Purpose: converter clock request and tick between control and divider
// Assumes: single cpu clock domain
// Notes:   tick is a one-cycle enable, not a clock
`timescale 1ns/1ps
`default_nettype none
interface adcsq_clk_if;
  logic slow;
  logic speed;
  logic run;
  logic tick;
  modport ctrl (output slow, output speed, output run, input tick);
  modport div  (input slow, input speed, input run, output tick);
endinterface : adcsq_clk_if
`default_nettype wire

// File: hdl/adcsq_clkdiv.sv
// Purpose: converter clock enable derived from the cpu clock
// Assumes: select bits come from registers on the same clock
// Notes:   phase restarts whenever run is low
`timescale 1ns/1ps
`default_nettype none
module adcsq_clkdiv (
  input wire logic    i_clk,
  input wire logic    i_rst_n,
  adcsq_clk_if.div    clk_if
);

  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } adcsq_div_st_t;

  adcsq_div_st_t st_ff;
  adcsq_div_st_t nxt_st;
  logic [1:0]    term;

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    case ({clk_if.slow, clk_if.speed}) // RL16
      adcsq_pkg::SEL_FULL:    term = adcsq_pkg::TERM_FULL;
      adcsq_pkg::SEL_QUARTER: term = adcsq_pkg::TERM_QUARTER;
      default:                term = adcsq_pkg::TERM_HALF;
    endcase
    if (!clk_if.run) begin
      nxt_st.cnt = 2'h0;
    end else if (st_ff.cnt >= term) begin
      nxt_st.cnt  = 2'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 2'h1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign clk_if.tick = st_ff.tick;

endmodule : adcsq_clkdiv
`default_nettype wire

// File: hdl/adcsq_ctrl.sv
// Purpose: control, sequencing and result registers of a 10-bit SAR converter
// Assumes: APB slave, comparator pin high when input is above the trial level
// Notes:   one access cycle per APB transfer, no wait states
`timescale 1ns/1ps
`default_nettype none

// How it works
// (RL1) above high reference reads FFh / 03h
// (RL2) below low reference reads zero
// (RL3) result monotonic in input
// (RL4) software sets pins plain inputs first
// (RL5) enable powers converter, converts continuously
// (RL6) each completion sets flag, stores result
// (RL7) reading high result clears flag
// (RL8) any control/status write clears flag
// (RL9) software polls, reads low, then high
// (RL10) eight bits: poll, read high only
// (RL11) channel change aborts, clears flag, restarts
// (RL12) reading low result locks the pair
// (RL13) high read or disable unlocks pair
// (RL14) locked pair never updated
// (RL15) clearing enable stops and powers down
// (RL16) slow/speed choose converter clock divider
// (RL17) channel field selects input by value
// (RL18) control/status layout, resets to 00h
// (RL19) high holds bits 9:2, low 1:0
// (RL20) cpu wait mode has no effect
// (RL21) halt disables; wakeup needs settle time
// (RL22) fixed tick count per conversion
module adcsq_ctrl #(
  parameter int unsigned SAMPLE_TICKS = adcsq_pkg::SAMPLE_TICKS,
  parameter int unsigned BIT_TICKS    = adcsq_pkg::BIT_TICKS,
  parameter int unsigned STAB_CYC     = adcsq_pkg::STAB_CYC
) (
  input  wire logic        I_CLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic             O_PREADY,
  output logic [31:0]      O_PRDATA,
  output logic             O_PSLVERR,
  input  wire logic        I_HALT,
  input  wire logic        I_CMP,
  output logic             O_ADC_ON,
  output logic [3:0]       O_CH_SEL,
  output logic             O_SAMPLE,
  output logic [9:0]       O_DAC_CODE
);

  localparam int unsigned CW = adcsq_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    adcsq_pkg::adcsq_fsm_t fsm;
    logic [CW-1:0]         cnt;
    logic [3:0]            bitn;
    logic [9:0]            dac;
    logic [9:0]            result;
    logic                  eoc;
    logic                  speed;
    logic                  en;
    logic                  slow;
    logic [3:0]            ch;
    logic                  locked;
    logic                  settle_pend;
    logic                  cmp_m;
    logic                  cmp_s;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic                  sample;
    logic                  adc_on;
  } adcsq_ctrl_st_t;

  adcsq_ctrl_st_t st_ff;
  adcsq_ctrl_st_t nxt_st;

  adcsq_clk_if clk_if ();

  logic          setup;
  logic          hit_csr;
  logic          hit_hi;
  logic          hit_lo;
  logic          wr_csr;
  logic          rd_hi;
  logic          rd_lo;
  logic          ch_change;
  logic          en_new;
  logic          run_ok;
  logic          done;
  logic [7:0]    csr_val;
  logic [31:0]   rdata;
  logic          rerr;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // reload of a phase counter for a phase of n units
  function automatic logic [CW-1:0] load_cnt(input int unsigned n);
    load_cnt = CW'(n - 1);
  endfunction : load_cnt

  // one step down of a phase counter, callers stop it at zero
  function automatic logic [CW-1:0] dec_cnt(input logic [CW-1:0] c);
    dec_cnt = c - CW'(1);
  endfunction : dec_cnt

  ////////////////////////////////////////////////////////////////////////
  // converter clock enable
  assign clk_if.slow  = st_ff.slow;
  assign clk_if.speed = st_ff.speed;
  assign clk_if.run   = (st_ff.fsm == adcsq_pkg::ST_SAMPLE) ||
                        (st_ff.fsm == adcsq_pkg::ST_CONV);

  adcsq_clkdiv u_div (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .clk_if  (clk_if)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  always_comb begin
    csr_val = {st_ff.eoc, st_ff.speed, st_ff.en, st_ff.slow, st_ff.ch}; // RL18
    rdata   = 32'h0000_0000;
    rerr    = 1'b0;
    hit_csr = 1'b0;
    hit_hi  = 1'b0;
    hit_lo  = 1'b0;
    if (I_PADDR == adcsq_pkg::ADDR_CSR) begin
      hit_csr = 1'b1;
      rdata   = {24'h00_0000, csr_val};
    end else if (I_PADDR == adcsq_pkg::ADDR_HI) begin
      hit_hi  = 1'b1;
      rdata   = {24'h00_0000, st_ff.result[9:adcsq_pkg::RES_HI_LSB]}; // RL19
    end else if (I_PADDR == adcsq_pkg::ADDR_LO) begin
      hit_lo  = 1'b1;
      rdata   = {24'h00_0000, 6'h00, st_ff.result[1:0]}; // RL19
    end else begin
      rerr    = 1'b1;
    end
  end

  // side effects act in the setup cycle, which always completes next edge
  assign setup     = I_PSEL & ~I_PENABLE & ~st_ff.pready;
  assign wr_csr    = setup & I_PWRITE & hit_csr;
  assign rd_hi     = setup & ~I_PWRITE & hit_hi;
  assign rd_lo     = setup & ~I_PWRITE & hit_lo;
  assign ch_change = wr_csr & (I_PWDATA[3:0] != st_ff.ch);
  assign en_new    = wr_csr ? I_PWDATA[adcsq_pkg::CSR_EN] : st_ff.en;
  // cpu wait mode is deliberately not an input: it changes nothing
  assign run_ok    = en_new & ~I_HALT; // RL20

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    nxt_st         = st_ff;
    done           = 1'b0;

    // comparator pin crosses in through two flops
    nxt_st.cmp_m   = I_CMP;
    nxt_st.cmp_s   = st_ff.cmp_m;

    // bus answer
    nxt_st.pready  = setup;
    if (setup) begin
      nxt_st.prdata  = I_PWRITE ? 32'h0000_0000 : rdata;
      nxt_st.pslverr = rerr;
    end else begin
      nxt_st.pslverr = 1'b0;
    end

    // software fields, flag bit is not writable
    if (wr_csr) begin
      nxt_st.speed = I_PWDATA[adcsq_pkg::CSR_SPEED]; // RL16
      nxt_st.en    = I_PWDATA[adcsq_pkg::CSR_EN];
      nxt_st.slow  = I_PWDATA[adcsq_pkg::CSR_SLOW]; // RL16
      nxt_st.ch    = I_PWDATA[adcsq_pkg::CH_W-1:0]; // RL17
    end

    // sequence
    case (st_ff.fsm)
      adcsq_pkg::ST_OFF: begin
        if (run_ok) begin
          if (st_ff.settle_pend) begin
            nxt_st.fsm = adcsq_pkg::ST_SETTLE; // RL21
            nxt_st.cnt = load_cnt(STAB_CYC);
          end else begin
            nxt_st.fsm = adcsq_pkg::ST_SAMPLE; // RL5
            nxt_st.cnt = load_cnt(SAMPLE_TICKS);
          end
        end
      end
      adcsq_pkg::ST_SETTLE: begin
        // counts cpu cycles, not converter ticks
        if (st_ff.cnt == '0) begin
          nxt_st.settle_pend = 1'b0; // RL21
          nxt_st.fsm         = adcsq_pkg::ST_SAMPLE;
          nxt_st.cnt         = load_cnt(SAMPLE_TICKS);
        end else begin
          nxt_st.cnt = dec_cnt(st_ff.cnt);
        end
      end
      adcsq_pkg::ST_SAMPLE: begin
        if (clk_if.tick) begin
          if (st_ff.cnt == '0) begin
            nxt_st.fsm  = adcsq_pkg::ST_CONV;
            nxt_st.bitn = 4'h9;
            nxt_st.dac  = adcsq_pkg::RES_MSB1; // RL3
            nxt_st.cnt  = load_cnt(BIT_TICKS); // RL22
          end else begin
            nxt_st.cnt = dec_cnt(st_ff.cnt);
          end
        end
      end
      adcsq_pkg::ST_CONV: begin
        if (clk_if.tick) begin
          if (st_ff.cnt == '0) begin
            // keep trial bit while input is above it: saturates at
            // all ones above range and all zeros below it
            nxt_st.dac[st_ff.bitn] = st_ff.cmp_s; // RL1 RL2 RL3
            if (st_ff.bitn == 4'h0) begin
              done       = 1'b1; // RL22
              nxt_st.fsm = adcsq_pkg::ST_SAMPLE; // RL5
              nxt_st.cnt = load_cnt(SAMPLE_TICKS);
            end else begin
              nxt_st.bitn                  = st_ff.bitn - 4'h1;
              nxt_st.dac[st_ff.bitn - 4'h1] = 1'b1;
              nxt_st.cnt                   = load_cnt(BIT_TICKS);
            end
          end else begin
            nxt_st.cnt = dec_cnt(st_ff.cnt);
          end
        end
      end
      default: begin
        nxt_st.fsm = adcsq_pkg::ST_OFF;
      end
    endcase

    // stop and restart take priority over the sequence
    if (I_HALT) begin
      nxt_st.settle_pend = 1'b1; // RL21
    end
    if (!run_ok) begin
      nxt_st.fsm = adcsq_pkg::ST_OFF; // RL15 RL21
      nxt_st.cnt = '0;
    end else if (ch_change && st_ff.fsm != adcsq_pkg::ST_OFF &&
                 st_ff.fsm != adcsq_pkg::ST_SETTLE) begin
      nxt_st.fsm = adcsq_pkg::ST_SAMPLE; // RL11
      nxt_st.cnt = load_cnt(SAMPLE_TICKS);
    end

    // a sample that completes on the edge of a low read is dropped,
    // otherwise the pair would mix two samples
    if (done && !st_ff.locked && !rd_lo) begin
      nxt_st.result = nxt_st.dac; // RL6 RL14
    end

    // pair lock
    if (rd_lo) begin
      nxt_st.locked = 1'b1; // RL12
    end
    if (rd_hi || !en_new) begin
      nxt_st.locked = 1'b0; // RL13
    end

    // completion flag: set wins over every clear
    if (rd_hi) begin
      nxt_st.eoc = 1'b0; // RL7
    end
    if (wr_csr) begin
      nxt_st.eoc = 1'b0; // RL8 RL11
    end
    if (done) begin
      nxt_st.eoc = 1'b1; // RL6
    end

    // pin outputs
    nxt_st.sample = (nxt_st.fsm == adcsq_pkg::ST_SAMPLE);
    nxt_st.adc_on = run_ok; // RL5 RL15
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      st_ff             <= '0;
      st_ff.fsm         <= adcsq_pkg::ST_OFF;
      st_ff.result      <= adcsq_pkg::RES_RST;
      {st_ff.eoc, st_ff.speed, st_ff.en, st_ff.slow, st_ff.ch} <= adcsq_pkg::CSR_RST; // RL18
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign O_PREADY   = st_ff.pready;
  assign O_PRDATA   = st_ff.prdata;
  assign O_PSLVERR  = st_ff.pslverr;
  assign O_ADC_ON   = st_ff.adc_on;
  assign O_CH_SEL   = st_ff.ch; // RL17
  assign O_SAMPLE   = st_ff.sample;
  assign O_DAC_CODE = st_ff.dac;

endmodule : adcsq_ctrl
`default_nettype wire

// File: hdl/adcsq_pkg.sv
// Purpose: shared constants and types of the converter control block
// Assumes: APB with 32-bit data, 40 MHz cpu clock
// Notes:   register byte address is four times the register index
package adcsq_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register map
  localparam int unsigned APB_AW   = 12;
  localparam logic [7:0]  IDX_CSR  = 8'h45;
  localparam logic [7:0]  IDX_HI   = 8'h46;
  localparam logic [7:0]  IDX_LO   = 8'h47;
  localparam logic [11:0] ADDR_CSR = {2'h0, IDX_CSR, 2'h0};
  localparam logic [11:0] ADDR_HI  = {2'h0, IDX_HI, 2'h0};
  localparam logic [11:0] ADDR_LO  = {2'h0, IDX_LO, 2'h0};

  ////////////////////////////////////////////////////////////////////////
  // control/status fields
  localparam int unsigned CSR_EOC   = 7;
  localparam int unsigned CSR_SPEED = 6;
  localparam int unsigned CSR_EN    = 5;
  localparam int unsigned CSR_SLOW  = 4;
  localparam int unsigned CH_W      = 4;
  localparam logic [7:0]  CSR_RST   = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // result layout
  localparam int unsigned RES_W     = 10;
  localparam int unsigned RES_HI_LSB = 2;
  localparam logic [9:0]  RES_RST   = 10'h000;
  localparam logic [9:0]  RES_MSB1  = 10'h200;

  ////////////////////////////////////////////////////////////////////////
  // converter clock select, index is {slow, speed}
  localparam logic [1:0]  SEL_HALF    = 2'h0;
  localparam logic [1:0]  SEL_FULL    = 2'h1;
  localparam logic [1:0]  SEL_QUARTER = 2'h2;
  localparam logic [1:0]  SEL_HALF_B  = 2'h3;
  localparam logic [1:0]  TERM_FULL    = 2'h0;
  localparam logic [1:0]  TERM_HALF    = 2'h1;
  localparam logic [1:0]  TERM_QUARTER = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_MHZ      = 40;
  localparam int unsigned STAB_NS      = 1000;
  localparam int unsigned STAB_CYC     = (STAB_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SAMPLE_TICKS = 4;
  localparam int unsigned BIT_TICKS    = 4;
  localparam int unsigned CNT_W        = 8;

  ////////////////////////////////////////////////////////////////////////
  // converter sequence
  typedef enum logic [3:0] {
    ST_OFF    = 4'h1,
    ST_SETTLE = 4'h2,
    ST_SAMPLE = 4'h4,
    ST_CONV   = 4'h8
  } adcsq_fsm_t;

endpackage : adcsq_pkg

// File: sim/adcsq_ctrl_checker.sv
// Purpose: port checker of adcsq_ctrl
// Assumes: one clock, async low reset
// Notes:   bound to the design below
`timescale 1ns/1ps
`default_nettype none
module adcsq_ctrl_checker #(
  parameter int unsigned SAMPLE_TICKS = 4,
  parameter int unsigned BIT_TICKS    = 4,
  parameter int unsigned STAB_CYC     = 2
) (
  input wire logic        I_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic        O_PREADY,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PSLVERR,
  input wire logic        I_HALT,
  input wire logic        I_CMP,
  input wire logic        O_ADC_ON,
  input wire logic [3:0]  O_CH_SEL,
  input wire logic        O_SAMPLE,
  input wire logic [9:0]  O_DAC_CODE
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  ////////////////////////////////////////
  logic setup;
  logic mapped;
  logic wr_csr;
  assign setup  = I_PSEL && !I_PENABLE;
  assign mapped = I_PADDR inside {adcsq_pkg::ADDR_CSR, adcsq_pkg::ADDR_HI, adcsq_pkg::ADDR_LO};
  assign wr_csr = setup && I_PWRITE && I_PADDR == adcsq_pkg::ADDR_CSR;
  sequence csr_wr_s; wr_csr; endsequence
  sequence rd_lo_s; setup && !I_PWRITE && I_PADDR == adcsq_pkg::ADDR_LO; endsequence
  sequence halted_s; I_HALT [*2]; endsequence
  AST_READY: assert property (setup |=> O_PREADY)
    else $error("no ready after setup");
  AST_UNMAPPED: assert property (setup && !mapped |=> O_PSLVERR && O_PRDATA == 32'h0)
    else $error("unmapped access not refused");
  AST_UPPER_ZERO: assert property (O_PREADY |-> O_PRDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_LOW_RSVD: assert property (rd_lo_s |=> O_PRDATA[7:2] == 6'h0)
    else $error("low result reserved bits set");
  AST_ON: assert property (csr_wr_s ##0 I_PWDATA[5] && !I_HALT ##1 !I_HALT |=> O_ADC_ON)
    else $error("converter not powered after enable");
  AST_OFF: assert property (csr_wr_s ##0 !I_PWDATA[5] |=> ##1 !O_ADC_ON)
    else $error("converter still powered after disable");
  AST_HALT: assert property (halted_s |-> !O_ADC_ON)
    else $error("converter powered in halt");
  AST_CH: assert property (csr_wr_s |=> ##1 O_CH_SEL == $past(I_PWDATA[3:0], 2))
    else $error("channel select wrong");
  AST_MSB: assert property ($fell(O_SAMPLE) && O_ADC_ON && !$past(wr_csr) && !$past(wr_csr, 2)
    && !$past(I_HALT) |-> O_DAC_CODE == adcsq_pkg::RES_MSB1)
    else $error("first trial code wrong");
endmodule : adcsq_ctrl_checker
bind adcsq_ctrl adcsq_ctrl_checker #(.SAMPLE_TICKS(SAMPLE_TICKS), .BIT_TICKS(BIT_TICKS), .STAB_CYC(STAB_CYC))
  u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
  .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY), .O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR),
  .I_HALT(I_HALT), .I_CMP(I_CMP), .O_ADC_ON(O_ADC_ON), .O_CH_SEL(O_CH_SEL), .O_SAMPLE(O_SAMPLE),
  .O_DAC_CODE(O_DAC_CODE));
`default_nettype wire

// File: sim/adcsq_ctrl_tb_top.sv
// Purpose: self-checking bench of adcsq_ctrl
// Assumes: comparator modelled from a digital input level
// Notes:   short settle count keeps the halt test brief
`timescale 1ns/1ps
`default_nettype none
module adc_sequencer_control_tb_top;
  typedef struct packed {logic [3:0] ch; logic [1:0] sel; logic [10:0] vin; logic [9:0] res;} adcsq_row_t;
  localparam logic [11:0] a_csr = adcsq_pkg::ADDR_CSR;
  localparam logic [11:0] a_hi  = adcsq_pkg::ADDR_HI;
  localparam logic [11:0] a_lo  = adcsq_pkg::ADDR_LO;
  logic        clk, rst_n, psel, penable, pwrite, halt, cmp, ready, slverr, adc_on, sample, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w;
  logic [3:0]  ch_sel;
  logic [9:0]  dac;
  logic [10:0] vin;
  int          failures, check_count, n, cyc[4];
  // vin above every code gives full scale, rows rise for monotonic check
  adcsq_row_t  rows[4] = '{'{4'h0, 2'h0, 11'h000, 10'h000}, '{4'h5, 2'h1, 11'h002, 10'h001},
                           '{4'ha, 2'h2, 11'h201, 10'h200}, '{4'hf, 2'h3, 11'h400, 10'h3ff}};
  adcsq_ctrl #(.STAB_CYC(2)) u_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PREADY(ready), .O_PRDATA(prdata),
    .O_PSLVERR(slverr), .I_HALT(halt), .I_CMP(cmp), .O_ADC_ON(adc_on), .O_CH_SEL(ch_sel),
    .O_SAMPLE(sample), .O_DAC_CODE(dac));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) cmp <= (vin > {1'b0, dac});
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ready !== 1'b1 && n < 20);
    rd = prdata;
    err = slverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) failures++;
  endtask : apb
  task automatic wait_eoc(output int k);
    k = 0;
    do begin
      apb(1'b0, a_csr, 32'h0);
      k++;
    end while (rd[7] !== 1'b1 && k < 300);
    if (k >= 300) failures++;
  endtask : wait_eoc
  task automatic finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    #1000000;
    failures++;
    finish_test();
  end
  ////////////////////////////////////////
  initial begin
    {rst_n, psel, penable, pwrite, halt} = 5'h0;
    {paddr, pwdata, vin} = '0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, a_csr, 32'h0);
      vin <= rows[i].vin;
      w = {24'h0, 1'b0, rows[i].sel[0], 1'b1, rows[i].sel[1], rows[i].ch};
      apb(1'b1, a_csr, w);
      @(negedge clk);
      chk("channel", {28'h0, rows[i].ch}, {28'h0, ch_sel});
      wait_eoc(cyc[i]);
      apb(1'b0, a_lo, 32'h0);
      chk("low", {30'h0, rows[i].res[1:0]}, rd);
      apb(1'b0, a_hi, 32'h0);
      chk("high", {24'h0, rows[i].res[9:2]}, rd);
      apb(1'b0, a_csr, 32'h0);
      chk("csr", w, rd);
    end
    chk("clock select", 1, {31'h0, cyc[1] < cyc[0] && cyc[0] < cyc[2] && cyc[3] <= cyc[0] + 2});
    // lock: stale pair must survive later conversions
    apb(1'b1, a_csr, 32'h63);
    wait_eoc(n);
    apb(1'b0, a_lo, 32'h0);
    vin <= 11'h000;
    repeat (120) @(posedge clk);
    apb(1'b0, a_hi, 32'h0);
    chk("locked high", 32'hff, rd);
    wait_eoc(n);
    apb(1'b0, a_hi, 32'h0);
    chk("unlocked high", 32'h0, rd);
    apb(1'b0, a_lo, 32'h0);
    vin <= 11'h400;
    apb(1'b1, a_csr, 32'h43);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("power", 0, {31'h0, adc_on});
    apb(1'b1, a_csr, 32'h63);
    wait_eoc(n);
    apb(1'b0, a_hi, 32'h0);
    chk("high after off", 32'hff, rd);
    wait_eoc(n);
    repeat (10) @(posedge clk);
    apb(1'b1, a_csr, 32'he4);
    @(negedge clk);
    chk("restart", 1, {31'h0, sample});
    apb(1'b0, a_csr, 32'h0);
    chk("csr after change", 32'h64, rd);
    apb(1'b1, a_hi, 32'h55);
    apb(1'b0, a_hi, 32'h0);
    chk("ro high", 32'hff, rd);
    apb(1'b0, 12'h000, 32'h0);
    chk("unmapped", 32'h1, {rd[30:0], err});
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("halt power", 0, {31'h0, adc_on});
    apb(1'b0, a_hi, 32'h0);
    halt <= 1'b0;
    vin <= 11'h000;
    wait_eoc(n);
    apb(1'b0, a_hi, 32'h0);
    chk("after halt", 32'h0, rd);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    foreach (cyc[i]) begin
      if (i < 3) begin
        apb(1'b0, a_csr + 12'(4 * i), 32'h0);
        chk("reset value", 32'h0, rd);
      end
    end
    finish_test();
  end
endmodule : adc_sequencer_control_tb_top
`default_nettype wire
